// ===== logic/dic_regs.svh
// register indices, field positions, codes and reset values of the interrupt block
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH

// register indices; byte address is four times the index
`define DIC_IDX_M_CMD      10'h020
`define DIC_IDX_M_DATA     10'h021
`define DIC_IDX_S_CMD      10'h0a0
`define DIC_IDX_S_DATA     10'h0a1
`define DIC_IDX_ACK        10'h100
`define DIC_IDX_CFG        10'h101
`define DIC_IDX_STAT       10'h102

// ahb-lite codes
`define DIC_HSIZE_WORD     3'h2
`define DIC_HTRANS_ACT     1

// command word fields
`define DIC_CW_INIT        4
`define DIC_CW_OCW3        3
`define DIC_ICW1_NEED4     0
`define DIC_ICW1_SINGLE    1
`define DIC_ICW1_LEVEL     3
`define DIC_ICW4_AUTOMATIC_END_OF_SERVICE      1
`define DIC_OCW3_ESMM      6
`define DIC_OCW3_SMM       5
`define DIC_OCW3_POLL      2
`define DIC_OCW3_RR        1
`define DIC_OCW3_RIS       0

// operation word 2 command codes, data bits 7:5
`define DIC_OP_ROT_AUTOMATIC_END_OF_SERVICE_CLR 3'h0
`define DIC_OP_EOI_NS      3'h1
`define DIC_OP_EOI_SP      3'h3
`define DIC_OP_ROT_AUTOMATIC_END_OF_SERVICE_SET 3'h4
`define DIC_OP_ROT_NS      3'h5
`define DIC_OP_SET_PRIO    3'h6
`define DIC_OP_ROT_SP      3'h7

// configuration register bits
`define DIC_CFG_KBD_DIS    0
`define DIC_CFG_RTC_DIS    1

// reset and init values, spurious vector level
`define DIC_BOTTOM_RST     3'h7
`define DIC_CASC_RST       3'h7
`define DIC_SPUR_LVL       3'h7

// request numbers with a fixed source
`define DIC_IRQ_TIMER      0
`define DIC_IRQ_KBD        1
`define DIC_IRQ_CASC       2
`define DIC_IRQ_RTC        8
`define DIC_IRQ_MOUSE      12
`define DIC_IRQ_FPU        13

`endif

// ===== logic/dic_pkg.sv
// types of the dual interrupt controller
package dic_pkg;

	typedef enum logic [1:0] {
		DIC_RUN = 2'b00,
		DIC_W2  = 2'b01,
		DIC_W3  = 2'b10,
		DIC_W4  = 2'b11
	} dic_phase_t;

	typedef struct packed {
		logic [7:0] request_latch_register;
		logic [7:0] in_service_register;
		logic [7:0] mask_register;
		logic [7:0] prev_req;
		logic [7:0] slave_map;
		dic_phase_t phase;
		logic [4:0] vbase;
		logic [2:0] bottom;
		logic [2:0] casc;
		logic       need4;
		logic       single;
		logic       level;
		logic       automatic_end_of_service;
		logic       rot_automatic_end_of_service;
		logic       smm;
		logic       poll;
		logic       rd_isr;
	} dic_ctl_t;

	typedef struct packed {
		dic_ctl_t [1:0] ctl;
		logic [31:0]    rdata;
		logic [9:0]     wr_idx;
		logic           wr_pend;
		logic           rdy;
		logic           int_line;
		logic           kbd_dis;
		logic           rtc_dis;
	} dic_top_t;

endpackage

// ===== logic/dic_prio_if.sv
// carrier between a controller's registers and its priority resolver
`timescale 1ns/1ns
interface dic_prio_if;
	logic [7:0] pend;
	logic [7:0] isr_block;
	logic [7:0] isr_open;
	logic [2:0] bottom;
	logic       pend_any;
	logic [2:0] pend_lvl;
	logic       eoi_any;
	logic [2:0] eoi_lvl;
	logic       int_req;

	modport res (
		input  pend,
		input  isr_block,
		input  isr_open,
		input  bottom,
		output pend_any,
		output pend_lvl,
		output eoi_any,
		output eoi_lvl,
		output int_req
	);

	modport user (
		output pend,
		output isr_block,
		output isr_open,
		output bottom,
		input  pend_any,
		input  pend_lvl,
		input  eoi_any,
		input  eoi_lvl,
		input  int_req
	);
endinterface

// ===== logic/dic_prio.sv
// rotating priority resolver for one eight-input controller
`timescale 1ns/1ns
module dic_prio (
	dic_prio_if.res pif
);
	logic [2:0] lv;
	logic       pa;
	logic [2:0] pl;
	logic       ia;
	logic [2:0] il;
	logic       ea;
	logic [2:0] el;

	// rank 0 is the input just above bottom, i.e. the highest
	function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] bot);
		return 3'(lvl - bot - 3'h1);
	endfunction

	// walk from lowest to highest so the last hit is the winner
	always_comb begin
		pa = 1'b0;
		pl = 3'h0;
		ia = 1'b0;
		il = 3'h0;
		ea = 1'b0;
		el = 3'h0;
		lv = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			lv = 3'(pif.bottom + 3'(i) + 3'h1);
			if (pif.pend[lv]) begin
				pa = 1'b1;
				pl = lv;
			end
			if (pif.isr_block[lv]) begin
				ia = 1'b1;
				il = lv;
			end
			if (pif.isr_open[lv]) begin
				ea = 1'b1;
				el = lv;
			end
		end
	end

	assign pif.pend_any = pa;
	assign pif.pend_lvl = pl;
	assign pif.eoi_any  = ea;
	assign pif.eoi_lvl  = el;
	// an equal or higher in-service level holds the line low
	assign pif.int_req  = pa && (!ia || (rank(pl, pif.bottom) < rank(il, pif.bottom)));
endmodule

// ===== logic/dic_top.sv
// two cascaded eight-input interrupt controllers behind an ahb-lite slave
`timescale 1ns/1ns
`include "dic_regs.svh"
// Summary of operation
// - two cascaded eight-input controllers resolve priority, raise interrupt, give vector.
// - request 0 comes from the timer; request 2 is the internal cascade.
// - keyboard disabled: request 1 from keyboard clock, 12 from mouse clock pin.
// - clock disabled: request 8 comes from the battery switch pin.
// - every new request edge sets its bit in the request latch; level mode follows the requests.
// - a set mask bit keeps that channel's request out of priority resolution.
// - resolution raises the interrupt; the acknowledge latches the winner into in-service.
// - an acknowledge returns the vector of the highest unmasked pending request.
// - specific end clears the named bit; non-specific clears highest unmasked.
// - automatic end leaves no in-service bit after the acknowledge.
// - fixed order by default: 0, 1, 8 to 15, then 3 to 7.
// - an in-service bit blocks interrupts from all lower priorities unless it is masked in special mask mode.
// - software may pick the bottom input; others follow wrapping around.
// - automatic rotation makes the just-serviced channel lowest.
// - polling mode keeps the line low; software reads the request latch.
// - command write with bit 4 set starts init and takes first word.
// - init start: fixed priority, bottom 7, mask clear, slave 7, no special mask.
// - following data writes load second, third (unless single) and fourth (if requested) init words.
// - a command write with bit 4 clear during init ends it and is an operation word.
// - outside init, data writes load the mask register.
// - command write with bit 4 clear: bit 3 picks word two or three.
// - vector is five programmed upper bits over the three-bit level.
module dic_top
	import dic_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [15:0] irq_pin,
	input  wire logic [15:0] pci_irq_req,
	input  wire logic        timer_irq,
	input  wire logic        kbd_irq,
	input  wire logic        mouse_irq,
	input  wire logic        rtc_alarm_irq,
	input  wire logic        keyboard_clock_pin,
	input  wire logic        mouse_clock_pin,
	input  wire logic        battery_switch_pin,
	input  wire logic        coprocessor_error_pin,
	output logic             cpu_interrupt_line
);
	dic_top_t    st_ff;
	dic_top_t    nxt_st;
	logic [15:0] req;
	logic [7:0]  ctl_irq [2];
	logic [1:0]  p_any;
	logic [1:0]  e_any;
	logic [1:0]  p_int;
	logic [2:0]  p_lvl [2];
	logic [2:0]  e_lvl [2];
	logic        addr_ok;
	logic        rd_req;
	logic [9:0]  idx;
	logic [7:0]  wd;
	logic        casc_hit;
	logic        ack_m;
	logic        ack_s;
	logic [7:0]  vector;
	logic [1:0]  cmd_wr;
	logic [1:0]  dat_wr;
	logic [31:0] rd_val;

	dic_prio_if pif [2] ();

	// request sources; timer and cascade never reach a pin
	genvar gi;
	for (gi = 0; gi < 16; gi++) begin : g_src
		if (gi == `DIC_IRQ_TIMER) begin : g_tmr
			assign req[gi] = timer_irq;
		end else if (gi == `DIC_IRQ_CASC) begin : g_csc
			assign req[gi] = 1'b0;
		end else if (gi == `DIC_IRQ_KBD) begin : g_kbd
			assign req[gi] = st_ff.kbd_dis ? keyboard_clock_pin : kbd_irq;
		end else if (gi == `DIC_IRQ_MOUSE) begin : g_ms
			assign req[gi] = st_ff.kbd_dis ? mouse_clock_pin : mouse_irq;
		end else if (gi == `DIC_IRQ_RTC) begin : g_rtc
			assign req[gi] = st_ff.rtc_dis ? battery_switch_pin : rtc_alarm_irq;
		end else if (gi == `DIC_IRQ_FPU) begin : g_fpu
			assign req[gi] = coprocessor_error_pin | pci_irq_req[gi];
		end else begin : g_pin
			assign req[gi] = irq_pin[gi] | pci_irq_req[gi];
		end
	end

	// second controller enters the first through input 2
	assign ctl_irq[0] = {req[7:3], p_int[1], req[1:0]};
	assign ctl_irq[1] = req[15:8];

	genvar gc;
	for (gc = 0; gc < 2; gc++) begin : g_ctl
		assign pif[gc].pend      = st_ff.ctl[gc].request_latch_register & ~st_ff.ctl[gc].mask_register;
		// special mask lets masked in-service levels stop blocking
		assign pif[gc].isr_block = st_ff.ctl[gc].smm ?
			(st_ff.ctl[gc].in_service_register & ~st_ff.ctl[gc].mask_register) : st_ff.ctl[gc].in_service_register;
		assign pif[gc].isr_open  = st_ff.ctl[gc].in_service_register & ~st_ff.ctl[gc].mask_register;
		assign pif[gc].bottom    = st_ff.ctl[gc].bottom;
		assign p_any[gc]         = pif[gc].pend_any;
		assign p_lvl[gc]         = pif[gc].pend_lvl;
		assign e_any[gc]         = pif[gc].eoi_any;
		assign e_lvl[gc]         = pif[gc].eoi_lvl;
		assign p_int[gc]         = pif[gc].int_req & ~st_ff.ctl[gc].poll;
		dic_prio u_prio (
			.pif (pif[gc])
		);
	end

	// next state of one controller
	function automatic dic_ctl_t ctl_next(
		input dic_ctl_t   c,
		input logic [7:0] irq,
		input logic       ack,
		input logic       cw,
		input logic       dw,
		input logic [7:0] d,
		input logic       pany,
		input logic [2:0] plvl,
		input logic       eany,
		input logic [2:0] elvl
	);
		dic_ctl_t   n;
		logic [7:0] clr;
		logic       hit;
		n   = c;
		hit = ack && pany;
		clr = hit ? 8'(8'h1 << plvl) : 8'h0;
		n.prev_req = irq;
		// a new edge in the acknowledge cycle is kept: set wins
		if (c.level) begin
			n.request_latch_register = irq;
		end else begin
			n.request_latch_register = (c.request_latch_register & ~clr) | (irq & ~c.prev_req);
		end
		if (cw && d[`DIC_CW_INIT]) begin
			n.phase    = DIC_W2;
			n.level    = d[`DIC_ICW1_LEVEL];
			n.single   = d[`DIC_ICW1_SINGLE];
			n.need4    = d[`DIC_ICW1_NEED4];
			n.mask_register      = 8'h00;
			n.bottom   = `DIC_BOTTOM_RST;
			n.casc     = `DIC_CASC_RST;
			n.smm      = 1'b0;
			n.rd_isr   = 1'b0;
			n.poll     = 1'b0;
			n.automatic_end_of_service     = 1'b0;
			n.rot_automatic_end_of_service = 1'b0;
			n.prev_req = 8'h00;
		end else if (cw) begin
			n.phase = DIC_RUN;
			if (d[`DIC_CW_OCW3]) begin
				if (d[`DIC_OCW3_ESMM]) begin
					n.smm = d[`DIC_OCW3_SMM];
				end
				n.poll = d[`DIC_OCW3_POLL];
				if (d[`DIC_OCW3_RR]) begin
					n.rd_isr = d[`DIC_OCW3_RIS];
				end
			end else begin
				case (d[7:5])
					`DIC_OP_EOI_NS: begin
						if (eany) begin
							n.in_service_register[elvl] = 1'b0;
						end
					end
					`DIC_OP_ROT_NS: begin
						if (eany) begin
							n.in_service_register[elvl] = 1'b0;
							n.bottom    = elvl;
						end
					end
					`DIC_OP_EOI_SP: begin
						n.in_service_register[d[2:0]] = 1'b0;
					end
					`DIC_OP_ROT_SP: begin
						n.in_service_register[d[2:0]] = 1'b0;
						n.bottom      = d[2:0];
					end
					`DIC_OP_SET_PRIO: begin
						n.bottom = d[2:0];
					end
					`DIC_OP_ROT_AUTOMATIC_END_OF_SERVICE_SET: begin
						n.rot_automatic_end_of_service = 1'b1;
					end
					`DIC_OP_ROT_AUTOMATIC_END_OF_SERVICE_CLR: begin
						n.rot_automatic_end_of_service = 1'b0;
					end
					default: begin
						n.rot_automatic_end_of_service = c.rot_automatic_end_of_service;
					end
				endcase
			end
		end else if (dw) begin
			case (c.phase)
				DIC_W2: begin
					n.vbase = d[7:3];
					if (!c.single) begin
						n.phase = DIC_W3;
					end else if (c.need4) begin
						n.phase = DIC_W4;
					end else begin
						n.phase = DIC_RUN;
					end
				end
				DIC_W3: begin
					n.slave_map = d;
					n.casc      = d[2:0];
					n.phase     = c.need4 ? DIC_W4 : DIC_RUN;
				end
				DIC_W4: begin
					n.automatic_end_of_service  = d[`DIC_ICW4_AUTOMATIC_END_OF_SERVICE];
					n.phase = DIC_RUN;
				end
				DIC_RUN: begin
					n.mask_register = d;
				end
				default: begin
					n.phase = DIC_RUN;
				end
			endcase
		end
		// acknowledge sets in-service after any end command of this cycle
		if (hit) begin
			if (!c.automatic_end_of_service) begin
				n.in_service_register[plvl] = 1'b1;
			end else if (c.rot_automatic_end_of_service) begin
				n.bottom = plvl;
			end
		end
		return n;
	endfunction

	// ahb address phase; only whole-word transfers are taken
	assign addr_ok = hsel && hready && htrans[`DIC_HTRANS_ACT] && (hsize == `DIC_HSIZE_WORD);
	assign rd_req  = addr_ok && !hwrite;
	assign idx     = haddr[11:2];
	assign wd      = hwdata[7:0];

	// vector: cascade input defers to the second controller
	always_comb begin
		casc_hit = st_ff.ctl[0].slave_map[p_lvl[0]] && (p_lvl[0] == st_ff.ctl[1].casc);
		ack_m    = rd_req && (idx == `DIC_IDX_ACK);
		ack_s    = ack_m && p_any[0] && casc_hit;
		if (!p_any[0]) begin
			vector = {st_ff.ctl[0].vbase, `DIC_SPUR_LVL};
		end else if (casc_hit) begin
			vector = {st_ff.ctl[1].vbase, p_any[1] ? p_lvl[1] : `DIC_SPUR_LVL};
		end else begin
			vector = {st_ff.ctl[0].vbase, p_lvl[0]};
		end
	end

	// read mux; status of the command port follows the read select
	always_comb begin
		case (idx)
			`DIC_IDX_M_CMD: begin
				rd_val = {24'h0, st_ff.ctl[0].rd_isr ? st_ff.ctl[0].in_service_register : st_ff.ctl[0].request_latch_register};
			end
			`DIC_IDX_M_DATA: begin
				rd_val = {24'h0, st_ff.ctl[0].mask_register};
			end
			`DIC_IDX_S_CMD: begin
				rd_val = {24'h0, st_ff.ctl[1].rd_isr ? st_ff.ctl[1].in_service_register : st_ff.ctl[1].request_latch_register};
			end
			`DIC_IDX_S_DATA: begin
				rd_val = {24'h0, st_ff.ctl[1].mask_register};
			end
			`DIC_IDX_ACK: begin
				rd_val = {24'h0, vector};
			end
			`DIC_IDX_CFG: begin
				rd_val = {30'h0, st_ff.rtc_dis, st_ff.kbd_dis};
			end
			`DIC_IDX_STAT: begin
				rd_val = {30'h0, p_int[1], st_ff.int_line};
			end
			default: begin
				rd_val = 32'h0;
			end
		endcase
	end

	// write data phase strobes
	always_comb begin
		cmd_wr[0] = st_ff.wr_pend && (st_ff.wr_idx == `DIC_IDX_M_CMD);
		cmd_wr[1] = st_ff.wr_pend && (st_ff.wr_idx == `DIC_IDX_S_CMD);
		dat_wr[0] = st_ff.wr_pend && (st_ff.wr_idx == `DIC_IDX_M_DATA);
		dat_wr[1] = st_ff.wr_pend && (st_ff.wr_idx == `DIC_IDX_S_DATA);
	end

	always_comb begin
		nxt_st         = st_ff;
		nxt_st.rdy     = 1'b1;
		nxt_st.wr_pend = addr_ok && hwrite;
		nxt_st.wr_idx  = idx;
		nxt_st.rdata   = rd_req ? rd_val : 32'h0;
		nxt_st.ctl[0]  = ctl_next(st_ff.ctl[0], ctl_irq[0], ack_m, cmd_wr[0], dat_wr[0], wd,
			p_any[0], p_lvl[0], e_any[0], e_lvl[0]);
		nxt_st.ctl[1]  = ctl_next(st_ff.ctl[1], ctl_irq[1], ack_s, cmd_wr[1], dat_wr[1], wd,
			p_any[1], p_lvl[1], e_any[1], e_lvl[1]);
		nxt_st.int_line = p_int[0];
		if (st_ff.wr_pend && (st_ff.wr_idx == `DIC_IDX_CFG)) begin
			nxt_st.kbd_dis = wd[`DIC_CFG_KBD_DIS];
			nxt_st.rtc_dis = wd[`DIC_CFG_RTC_DIS];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff               <= '0;
			st_ff.rdy           <= 1'b1;
			st_ff.ctl[0].bottom <= `DIC_BOTTOM_RST;
			st_ff.ctl[1].bottom <= `DIC_BOTTOM_RST;
			st_ff.ctl[0].casc   <= `DIC_CASC_RST;
			st_ff.ctl[1].casc   <= `DIC_CASC_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// zero-wait slave, response always okay
	assign hrdata             = st_ff.rdata;
	assign hreadyout          = st_ff.rdy;
	assign hresp              = 1'b0;
	assign cpu_interrupt_line = st_ff.int_line;
endmodule

// ===== sim/dic_top_chk.sv
// bus-side assertion checker of the dual interrupt controller
`timescale 1ns/1ns
`include "dic_regs.svh"
module dic_top_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        cpu_interrupt_line
);
	logic       v_ff, w_ff, poll_ff;
	logic [9:0] a_ff;
	logic [1:0] cnt_ff;
	wire        take = hsel && hready && htrans[1] && hsize == `DIC_HSIZE_WORD;
	wire        wph  = v_ff && w_ff;
	wire        rph  = v_ff && !w_ff;
	wire        mcmd = wph && a_ff == `DIC_IDX_M_CMD;
	wire        mdat = wph && a_ff == `DIC_IDX_M_DATA;
	// init words still due, so a data write is known to be a mask write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			v_ff <= 1'b0;
			w_ff <= 1'b0;
			a_ff <= 10'h0;
			cnt_ff <= 2'h0;
			poll_ff <= 1'b0;
		end else begin
			v_ff <= take;
			w_ff <= hwrite;
			a_ff <= haddr[11:2];
			if (mcmd && hwdata[4]) begin
				cnt_ff <= 2'h1 + {1'b0, !hwdata[1]} + {1'b0, hwdata[0]};
				poll_ff <= 1'b0;
			end else if (mcmd) begin
				cnt_ff <= 2'h0;
				if (hwdata[3])
					poll_ff <= hwdata[2];
			end else if (mdat && cnt_ff != 2'h0)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_rd(logic [9:0] x);
		take && !hwrite && haddr[11:2] == x;
	endsequence
	sequence s_icw1;
		mcmd && hwdata[4];
	endsequence
	sequence s_wr(logic [9:0] x);
		wph && a_ff == x && cnt_ff == 2'h0;
	endsequence
	AST_NO_WAIT: assert property (hreadyout && !hresp)
		else $error("bus answer late or not okay");
	AST_RD_IDLE: assert property (!rph |-> hrdata == 32'h0)
		else $error("read data outside a read data phase");
	AST_ACK_VEC: assert property (rph && a_ff == `DIC_IDX_ACK |-> hrdata[31:8] == 24'h0)
		else $error("vector wider than one byte");
	AST_MASK_CLR: assert property (s_icw1 ##1 s_rd(`DIC_IDX_M_DATA) |=> hrdata == 32'h0)
		else $error("mask not cleared by init start");
	AST_MASK_RW: assert property (s_wr(`DIC_IDX_M_DATA) ##1 s_rd(`DIC_IDX_M_DATA)
		|=> hrdata[7:0] == $past(hwdata[7:0], 2))
		else $error("mask read differs from write");
	AST_CFG_RW: assert property (s_wr(`DIC_IDX_CFG) ##1 s_rd(`DIC_IDX_CFG)
		|=> hrdata[1:0] == $past(hwdata[1:0], 2))
		else $error("source select read differs");
	AST_STAT_LINE: assert property (s_rd(`DIC_IDX_STAT) |=> hrdata[0] == $past(cpu_interrupt_line))
		else $error("status line bit wrong");
	AST_POLL_QUIET: assert property (poll_ff && $past(poll_ff) |-> !cpu_interrupt_line)
		else $error("interrupt raised while polling");
endmodule
bind dic_top dic_top_chk i_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .cpu_interrupt_line(cpu_interrupt_line)
);

// ===== sim/dic_host.sv
// host cpu model: ahb-lite master doing i/o writes and acknowledges
`timescale 1ns/1ns
module dic_host (
	input  wire logic        hclk,
	input  wire logic        hreadyout,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// sampled before the edge, so no race with the slave's own update
	task automatic wait_rdy(output logic [31:0] q);
		logic r;
		do begin
			@(negedge hclk);
			r = hreadyout;
			q = hrdata;
			@(posedge hclk);
		end while (r !== 1'b1);
	endtask
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy(q);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(q);
		hwdata <= ~d;
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, {24'h0, d}, q);
	endtask
	// mask is read back right after the first word
	task automatic init(input logic [31:0] c, input logic [7:0] w2, w3, w4,
		output logic [31:0] m);
		wr(c, 8'h11);
		xfer(c + 32'h4, 1'b0, 32'h0, m);
		wr(c + 32'h4, w2);
		wr(c + 32'h4, w3);
		wr(c + 32'h4, w4);
	endtask
endmodule

// ===== sim/tb.sv
// self-checking bench of the dual interrupt controller
`timescale 1ns/1ns
`include "dic_regs.svh"
module tb;
	localparam logic [31:0] MC  = {20'h0, `DIC_IDX_M_CMD, 2'b00};
	localparam logic [31:0] MD  = {20'h0, `DIC_IDX_M_DATA, 2'b00};
	localparam logic [31:0] SC  = {20'h0, `DIC_IDX_S_CMD, 2'b00};
	localparam logic [31:0] SD  = {20'h0, `DIC_IDX_S_DATA, 2'b00};
	localparam logic [31:0] ACK = {20'h0, `DIC_IDX_ACK, 2'b00};
	localparam logic [31:0] CFG = {20'h0, `DIC_IDX_CFG, 2'b00};
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_interrupt_line;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [15:0] irq_pin, pci_irq_req;
	logic        timer_irq, kbd_irq, mouse_irq, rtc_alarm_irq;
	logic        keyboard_clock_pin, mouse_clock_pin, battery_switch_pin, coprocessor_error_pin;
	int          fail_count, num_checks, cyc;
	dic_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pin(irq_pin),
		.pci_irq_req(pci_irq_req), .timer_irq(timer_irq), .kbd_irq(kbd_irq),
		.mouse_irq(mouse_irq), .rtc_alarm_irq(rtc_alarm_irq),
		.keyboard_clock_pin(keyboard_clock_pin), .mouse_clock_pin(mouse_clock_pin),
		.battery_switch_pin(battery_switch_pin), .coprocessor_error_pin(coprocessor_error_pin),
		.cpu_interrupt_line(cpu_interrupt_line));
	dic_host i_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	always #4 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		i_host.xfer(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask
	// hold=1 watches the full window: absence of a rise needs time
	task automatic line_chk(input logic e, input bit hold);
		for (int n = 0; n < 8; n++) begin
			@(negedge hclk);
			if (!hold && cpu_interrupt_line === e)
				break;
		end
		chk({31'h0, cpu_interrupt_line}, {31'h0, e});
		@(posedge hclk);
	endtask
	task automatic t_regs();
		chk({30'h0, hreadyout, hresp}, 32'h2);
		i_host.wr(MD, 8'h5a);
		rdc(MD, 32'h5a);
		i_host.wr(SD, 8'ha5);
		i_host.init(MC, 8'h08, 8'h04, 8'h01, q);
		chk(q, 32'h0);
		i_host.init(SC, 8'h70, 8'h02, 8'h01, q);
		chk(q, 32'h0);
		i_host.wr(CFG, 8'h03);
		rdc(CFG, 32'h3);
		i_host.wr(CFG, 8'h00);
		rdc(CFG + 32'h4, 32'h0);
		rdc(CFG + 32'h8, 32'h0);
	endtask
	task automatic t_fixed();
		timer_irq <= 1'b1;
		irq_pin[3] <= 1'b1;
		line_chk(1'b1, 0);
		rdc(ACK, 32'h08);
		line_chk(1'b0, 1);
		i_host.wr(MC, 8'h20);
		line_chk(1'b1, 0);
		rdc(ACK, 32'h0b);
		i_host.wr(MC, 8'h63);
		timer_irq <= 1'b0;
		irq_pin <= 16'h0;
		i_host.wr(MC, 8'h0b);
		rdc(MC, 32'h0);
		i_host.wr(MC, 8'h0a);
	endtask
	task automatic t_mask();
		i_host.wr(MD, 8'h08);
		irq_pin <= 16'h000d;
		line_chk(1'b0, 1);
		rdc(MC, 32'h08);
		i_host.wr(MD, 8'h00);
		line_chk(1'b1, 0);
		rdc(ACK, 32'h0b);
		i_host.wr(MC, 8'h20);
		irq_pin <= 16'h0400;
		line_chk(1'b1, 0);
		rdc(ACK, 32'h72);
		// fresh edge on input 3; it waits behind the cascade in service
		irq_pin[3] <= 1'b1;
		i_host.wr(SC, 8'h20);
		i_host.wr(MC, 8'h20);
		line_chk(1'b1, 0);
		rdc(ACK, 32'h0b);
		i_host.wr(MC, 8'h20);
		irq_pin <= 16'h0;
	endtask
	task automatic t_rot();
		i_host.wr(MC, 8'h0c);
		timer_irq <= 1'b1;
		irq_pin[3] <= 1'b1;
		line_chk(1'b0, 1);
		rdc(MC, 32'h09);
		i_host.wr(MC, 8'h08);
		i_host.wr(MC, 8'hc2);
		line_chk(1'b1, 0);
		rdc(ACK, 32'h0b);
		irq_pin[4] <= 1'b1;
		i_host.wr(MC, 8'ha0);
		line_chk(1'b1, 0);
		rdc(ACK, 32'h0c);
		i_host.wr(MC, 8'h20);
		line_chk(1'b1, 0);
		rdc(ACK, 32'h08);
		i_host.wr(MC, 8'h20);
		i_host.wr(MC, 8'hc7);
		timer_irq <= 1'b0;
		irq_pin <= 16'h0;
		i_host.init(MC, 8'h08, 8'h04, 8'h03, q);
		timer_irq <= 1'b1;
		line_chk(1'b1, 0);
		rdc(ACK, 32'h08);
		i_host.wr(MC, 8'h0b);
		rdc(MC, 32'h0);
		i_host.wr(MC, 8'h0a);
	endtask
	task automatic t_src();
		i_host.wr(MD, 8'hff);
		i_host.wr(SD, 8'hff);
		i_host.wr(CFG, 8'h03);
		keyboard_clock_pin <= 1'b1;
		mouse_clock_pin <= 1'b1;
		battery_switch_pin <= 1'b1;
		coprocessor_error_pin <= 1'b1;
		pci_irq_req[5] <= 1'b1;
		line_chk(1'b0, 1);
		i_host.xfer(MC, 1'b0, 32'h0, q);
		chk(q & 32'hfb, 32'h22);
		rdc(SC, 32'h31);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{hclk, hresetn, timer_irq, kbd_irq, mouse_irq, rtc_alarm_irq} = 6'h0;
		{keyboard_clock_pin, mouse_clock_pin, battery_switch_pin, coprocessor_error_pin} = 4'h0;
		irq_pin = 16'h0;
		pci_irq_req = 16'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_fixed();
		t_mask();
		t_rot();
		t_src();
		results();
	end
endmodule
